/* include/adcr_pkg.sv */
// Constants for the converter result register bank.
// Assumes a mode-3 serial link sampled by the system clock.
package adcr_pkg;
  localparam int            ADDR_W         = 6;
  localparam logic [5:0]    ADDR_STATUS    = 6'h00;
  localparam logic [5:0]    ADDR_MODE      = 6'h02;
  localparam logic [5:0]    ADDR_CHECKSUM  = 6'h03;
  localparam logic [5:0]    ADDR_DATA      = 6'h04;
  localparam logic [5:0]    ADDR_USER_BASE = 6'h20;
  localparam int            CMD_READ_BIT   = 6;
  localparam int            IFM_SHORT      = 0;
  localparam int            IFM_CHK_LO     = 2;
  localparam int            IFM_INTEG      = 5;
  localparam int            IFM_APPEND     = 6;
  localparam logic [15:0]   IFM_WRITE_MASK = 16'h006D;
  localparam logic [15:0]   MODE_RESET     = 16'h0000;
  localparam logic [15:0]   USER_RESET     = 16'h0000;
  localparam logic [23:0]   DATA_RESET     = 24'h000000;
  localparam logic [23:0]   CHECKSUM_RESET = 24'h000000;
  localparam int            SETUP_POL_BIT  = 12;
  localparam logic [1:0]    CHK_OFF        = 2'h0;
  localparam logic [1:0]    CHK_XOR        = 2'h1;
  localparam logic [1:0]    CHK_CRC        = 2'h2;
  localparam logic [7:0]    CRC_POLY       = 8'h07;
  localparam logic [2:0]    USER_BYTES     = 3'h2;
  typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} adcr_state_t;
endpackage

/* logic/adcr_result_regs.sv */
// Result register bank with serial register access, checksum and data hold-off.
// Assumes link pins are asynchronous to mclk and the conversion inputs share mclk.
// Behaviour
// - Checksum mode 01: reads get an XOR byte, writes still carry a CRC.
// - Checksum mode 10: reads and writes carry a CRC byte, checked here.
// - Interface mode bit 1 is reserved, resets zero, always reads zero.
// - Short word select bit 0 chooses 24-bit or 16-bit data reads.
// - Mode writes leave the converter alone; new length applies to next result.
// - Checksum register at 0x03 is a read-only 24-bit XOR of user registers.
// - Checksum register reads zero while integrity checking is disabled.
// - Data register at 0x04 holds the latest result, read-only, resets zero.
// - Reading the data register drives the ready flag and pin high.
// - Data register may be reread and returns the same stored result.
// - After a data read command, new results do not overwrite the data until cs_n rises.
// - Append status adds the status byte after the result on data reads.
// - Checked register changes while enabled flag an integrity error; disabling clears.
// - Checksum protection lengthens each transfer by exactly one byte.
// - Appended status carries the channel latched with the returned result.
`timescale 1ns/1ps
module adcr_result_regs #(
  parameter int NUM_USER = 4
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  output logic             rdy_n,
  input  wire logic        conv_start,
  input  wire logic        conv_valid,
  input  wire logic [23:0] conv_data,
  input  wire logic [3:0]  conv_channel,
  output logic             polarity_select
);
  if (NUM_USER < 1 || NUM_USER > 31) begin : g_check
    $error("NUM_USER out of range");
  end

  function automatic logic [7:0] crc8(input logic [39:0] d, input logic [5:0] n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 40; i++) begin
      if (i < int'(n)) begin
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[39-i]) ? adcr_pkg::CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] xor8(input logic [39:0] d, input logic [5:0] n);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < 5; i++) begin
      x = x ^ ((i * 8 < int'(n)) ? d[39-8*i -: 8] : 8'h00);
    end
    return x;
  endfunction

  function automatic logic is_user(input logic [5:0] a);
    return (a >= adcr_pkg::ADDR_USER_BASE) &&
           (int'(a) - int'(adcr_pkg::ADDR_USER_BASE) < NUM_USER);
  endfunction

  logic [2:0]  s_sclk;
  logic [1:0]  s_cs;
  logic [1:0]  s_din;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_sclk <= 3'h7;
      s_cs   <= 2'h3;
      s_din  <= 2'h0;
    end else begin
      s_sclk <= {s_sclk[1:0], sclk};
      s_cs   <= {s_cs[0], cs_n};
      s_din  <= {s_din[0], din};
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = s_sclk[1] & ~s_sclk[2];
  assign sclk_fall = ~s_sclk[1] & s_sclk[2];

  adcr_pkg::adcr_state_t state, next_state;
  logic [5:0]  bit_cnt, next_bit_cnt;
  logic [5:0]  nbits, next_nbits;
  logic [7:0]  cmd, next_cmd;
  logic [39:0] rx_sr, next_rx_sr;
  logic [39:0] tx_sr, next_tx_sr;
  logic [15:0] mode_reg, next_mode_reg;
  logic [15:0] user [NUM_USER];
  logic [15:0] next_user [NUM_USER];
  logic [23:0] data_reg, next_data_reg;
  logic [3:0]  chan_reg, next_chan_reg;
  logic        next_rdy_n, hold, next_hold, reg_err, next_reg_err;
  logic        crc_err, next_crc_err, active_wl, next_active_wl;
  logic        next_dout, next_dout_oe, next_pol;
  logic [23:0] chk_calc;
  logic [7:0]  stat;
  logic [1:0]  chk_mode;

  always_comb begin
    chk_calc = 24'h000000;
    for (int i = 0; i < NUM_USER; i++) begin
      chk_calc = chk_calc ^ {8'h00, user[i]};
    end
  end
  assign stat     = {rdy_n, reg_err, crc_err, 1'b0, chan_reg};
  assign chk_mode = mode_reg[adcr_pkg::IFM_CHK_LO +: 2];

  always_comb begin
    logic [7:0]  c;
    logic [5:0]  a;
    logic [2:0]  nb;
    logic [31:0] v;
    logic [7:0]  cb;
    logic [39:0] rxn;
    logic [15:0] pay;
    int          ui;
    c = 8'h00;
    a = 6'h00;
    nb = 3'h1;
    v = 32'h00000000;
    cb = 8'h00;
    rxn = {rx_sr[38:0], s_din[1]};
    pay = 16'h0000;
    ui = 0;
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_nbits = nbits;
    next_cmd = cmd;
    next_rx_sr = rx_sr;
    next_tx_sr = tx_sr;
    next_mode_reg = mode_reg;
    next_user = user;
    next_data_reg = data_reg;
    next_chan_reg = chan_reg;
    next_rdy_n = rdy_n;
    next_hold = hold;
    next_reg_err = reg_err;
    next_crc_err = crc_err;
    next_active_wl = active_wl;
    next_dout = dout;
    next_dout_oe = dout_oe;
    next_pol = user[0][adcr_pkg::SETUP_POL_BIT];
    if (conv_start) begin
      next_active_wl = mode_reg[adcr_pkg::IFM_SHORT];
    end
    if (s_cs[1]) begin
      next_state = adcr_pkg::ST_CMD;
      next_bit_cnt = 6'h00;
      next_hold = 1'b0;
      next_dout_oe = 1'b0;
      next_dout = 1'b0;
    end else begin
      next_dout_oe = 1'b1;
      if (sclk_rise) begin
        next_bit_cnt = bit_cnt + 6'h01;
        unique case (state)
          adcr_pkg::ST_CMD: begin
            c = {cmd[6:0], s_din[1]};
            next_cmd = c;
            if (bit_cnt == 6'd7) begin
              a = c[5:0];
              next_bit_cnt = 6'h00;
              if (c[adcr_pkg::CMD_READ_BIT]) begin
                if (a == adcr_pkg::ADDR_STATUS) begin
                  v = {stat, 24'h000000};
                  next_crc_err = 1'b0;
                end else if (a == adcr_pkg::ADDR_MODE) begin
                  nb = 3'h2;
                  v = {mode_reg & adcr_pkg::IFM_WRITE_MASK, 16'h0000};
                end else if (a == adcr_pkg::ADDR_CHECKSUM) begin
                  nb = 3'h3;
                  v = {(mode_reg[adcr_pkg::IFM_INTEG] ? chk_calc : 24'h000000), 8'h00};
                end else if (a == adcr_pkg::ADDR_DATA) begin
                  next_rdy_n = 1'b1;
                  next_hold = 1'b1;
                  nb = mode_reg[adcr_pkg::IFM_SHORT] ? 3'h2 : 3'h3;
                  v = mode_reg[adcr_pkg::IFM_SHORT] ? {data_reg[15:0], stat, 8'h00} :
                      {data_reg, stat};
                  if (mode_reg[adcr_pkg::IFM_APPEND]) begin
                    nb = nb + 3'h1;
                  end else begin
                    v = v & ~(32'hFF000000 >> {nb, 3'b000});
                  end
                end else if (is_user(a)) begin
                  nb = adcr_pkg::USER_BYTES;
                  ui = int'(a) - int'(adcr_pkg::ADDR_USER_BASE);
                  v = {user[ui], 16'h0000};
                end
                cb = (chk_mode == adcr_pkg::CHK_XOR) ? xor8({c, v}, {nb, 3'b000} + 6'd8) :
                     crc8({c, v}, {nb, 3'b000} + 6'd8);
                next_tx_sr = {v, 8'h00};
                if (chk_mode != adcr_pkg::CHK_OFF) begin
                  next_tx_sr = {v, 8'h00} | ({32'h00000000, cb} << (6'd32 - {nb, 3'b000}));
                end
                next_state = adcr_pkg::ST_RD;
              end else begin
                next_state = adcr_pkg::ST_WR;
                nb = (a == adcr_pkg::ADDR_MODE || is_user(a)) ? adcr_pkg::USER_BYTES : 3'h1;
              end
              next_nbits = {nb, 3'b000} + ((chk_mode != adcr_pkg::CHK_OFF) ? 6'd8 : 6'd0);
            end
          end
          adcr_pkg::ST_WR: begin
            next_rx_sr = rxn;
            if (bit_cnt == nbits - 6'd1) begin
              next_state = adcr_pkg::ST_CMD;
              next_bit_cnt = 6'h00;
              a = cmd[5:0];
              pay = (chk_mode != adcr_pkg::CHK_OFF) ? rxn[23:8] : rxn[15:0];
              // Writes are CRC checked in both checksum modes
              if (chk_mode != adcr_pkg::CHK_OFF &&
                  crc8({cmd, pay, 16'h0000}, 6'd24) != rxn[7:0]) begin
                next_crc_err = 1'b1;
              end else if (a == adcr_pkg::ADDR_MODE) begin
                next_mode_reg = pay & adcr_pkg::IFM_WRITE_MASK;
                if (!pay[adcr_pkg::IFM_INTEG]) begin
                  next_reg_err = 1'b0;
                end
              end else if (is_user(a)) begin
                ui = int'(a) - int'(adcr_pkg::ADDR_USER_BASE);
                next_user[ui] = pay;
                if (mode_reg[adcr_pkg::IFM_INTEG] && pay != user[ui]) begin
                  next_reg_err = 1'b1;
                end
              end
            end
          end
          adcr_pkg::ST_RD: begin
            if (bit_cnt == nbits - 6'd1) begin
              next_state = adcr_pkg::ST_CMD;
              next_bit_cnt = 6'h00;
            end
          end
        endcase
      end else if (sclk_fall && state == adcr_pkg::ST_RD) begin
        // Bits leave on a fall so the host can take each one on the next rise
        next_tx_sr = {tx_sr[38:0], 1'b0};
        next_dout = tx_sr[39];
      end
    end
    // Result dropped, not queued, while a data read is pending
    if (conv_valid && !hold && !(s_cs[1] == 1'b0 && next_hold)) begin
      next_data_reg = active_wl ? {8'h00, conv_data[23:8]} : conv_data;
      next_chan_reg = conv_channel;
      next_rdy_n = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= adcr_pkg::ST_CMD;
      bit_cnt <= 6'h00;
      nbits <= 6'h00;
      cmd <= 8'h00;
      rx_sr <= 40'h0000000000;
      tx_sr <= 40'h0000000000;
      mode_reg <= adcr_pkg::MODE_RESET;
      for (int i = 0; i < NUM_USER; i++) begin
        user[i] <= adcr_pkg::USER_RESET;
      end
      data_reg <= adcr_pkg::DATA_RESET;
      chan_reg <= 4'h0;
      rdy_n <= 1'b1;
      hold <= 1'b0;
      reg_err <= 1'b0;
      crc_err <= 1'b0;
      active_wl <= 1'b0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      polarity_select <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      nbits <= next_nbits;
      cmd <= next_cmd;
      rx_sr <= next_rx_sr;
      tx_sr <= next_tx_sr;
      mode_reg <= next_mode_reg;
      user <= next_user;
      data_reg <= next_data_reg;
      chan_reg <= next_chan_reg;
      rdy_n <= next_rdy_n;
      hold <= next_hold;
      reg_err <= next_reg_err;
      crc_err <= next_crc_err;
      active_wl <= next_active_wl;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
      polarity_select <= next_pol;
    end
  end
endmodule

/* test/adcr_result_regs_asserts.sv */
// Port checks for the result register bank.
// Assumes the host holds cs_n low for a whole frame.
`timescale 1ns/1ps
module adcr_result_regs_asserts (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        din,
  input wire logic        dout,
  input wire logic        dout_oe,
  input wire logic        rdy_n,
  input wire logic        conv_start,
  input wire logic        conv_valid,
  input wire logic [23:0] conv_data,
  input wire logic [3:0]  conv_channel,
  input wire logic        polarity_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  quiet_dout_a: assert property (!dout_oe |-> !dout)
    else $error("dout high while undriven");
  drive_on_select_a: assert property ((!cs_n)[*5] |-> dout_oe)
    else $error("dout not driven in frame");
  result_ready_a: assert property (cs_n[*5] ##0 conv_valid |-> ##[1:2] !rdy_n)
    else $error("result not flagged");
  ready_cause_a: assert property ($fell(rdy_n) |-> $past(conv_valid) || $past(conv_valid, 2))
    else $error("ready without result");
  ready_cleared_a: assert property ($rose(rdy_n) |-> !$past(cs_n, 3))
    else $error("ready cleared outside read");
  hold_off_a: assert property ($rose(rdy_n) |=> rdy_n[*8])
    else $error("result taken during read");
  dout_stands_a: assert property (sclk[*8] ##0 (dout_oe && $past(dout_oe)) |-> $stable(dout))
    else $error("dout moved while sclk high");
  setup_steady_a: assert property (cs_n[*8] |-> $stable(polarity_select))
    else $error("polarity moved while idle");
  cover property ($fell(rdy_n));
  cover property ($rose(rdy_n));
  cover property ($rose(polarity_select));
endmodule
bind adcr_result_regs adcr_result_regs_asserts adcr_result_regs_asserts_inst (
  .mclk(mclk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
  .dout_oe(dout_oe), .rdy_n(rdy_n), .conv_start(conv_start), .conv_valid(conv_valid),
  .conv_data(conv_data), .conv_channel(conv_channel), .polarity_select(polarity_select)
);

/* test/adcr_host_model.sv */
// Host end of the serial register link, idle-high clock.
// Assumes mclk paces the link; one sclk period is 20 mclk.
`timescale 1ns/1ps
module adcr_host_model (
  input  wire logic mclk,
  input  wire logic dout,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Whole frame under one select; dout sampled just before each rise
  task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = 64'h0;
    cs_n = 1'b0;
    step(10);
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      step(10);
      rx = {rx[62:0], dout};
      sclk = 1'b1;
      step(10);
    end
    step(10);
    cs_n = 1'b1;
    din = ~din;
    step(20);
  endtask
endmodule

/* test/tb_top.sv */
// Register-level bench for the result register bank.
// Assumes the host model drives the link; conversions come from here.
`timescale 1ns/1ps
module tb_top;
  logic        mclk;
  logic        resetn;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        rdy_n;
  logic        conv_start;
  logic        conv_valid;
  logic [23:0] conv_data;
  logic [3:0]  conv_channel;
  logic        polarity_select;
  logic [63:0] rx;
  int          n_errors = 0;
  int          cmp_count = 0;
  adcr_result_regs adcr_result_regs_inst (.mclk(mclk), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .rdy_n(rdy_n),
    .conv_start(conv_start), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_channel(conv_channel), .polarity_select(polarity_select));
  adcr_host_model adcr_host_model_inst (.mclk(mclk), .dout(dout), .sclk(sclk),
    .cs_n(cs_n), .din(din));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // Mode 1 = good checksum byte, 2 = corrupted one
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input int cm);
    logic [63:0] r;
    logic [23:0] f;
    f = {2'b00, a, d};
    if (cm == 0) adcr_host_model_inst.xfer(24, {40'h0, f}, r);
    else adcr_host_model_inst.xfer(32, {32'h0, f, crc8(f) ^ {7'h00, cm == 2}}, r);
  endtask
  task automatic rd(input logic [5:0] a, input int nb, output logic [63:0] r);
    adcr_host_model_inst.xfer(8 + 8 * nb, {56'h0, 2'b01, a} << (8 * nb), r);
  endtask
  task automatic conv(input logic [23:0] d, input logic [3:0] ch);
    conv_start = 1'b1;
    step(1);
    conv_start = 1'b0;
    conv_data = d;
    conv_channel = ch;
    conv_valid = 1'b1;
    step(1);
    conv_valid = 1'b0;
    step(3);
  endtask
  task end_of_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    conv_start = 1'b0;
    conv_valid = 1'b0;
    conv_data = 24'h000000;
    conv_channel = 4'h0;
    repeat (16) @(posedge mclk);
    #1 resetn = 1'b1;
    step(4);
    rd(adcr_pkg::ADDR_MODE, 2, rx);
    chk(rx[15:0], adcr_pkg::MODE_RESET);
    rd(adcr_pkg::ADDR_CHECKSUM, 3, rx);
    chk(rx[23:0], adcr_pkg::CHECKSUM_RESET);
    rd(adcr_pkg::ADDR_DATA, 3, rx);
    chk(rx[23:0], adcr_pkg::DATA_RESET);
    rd(6'h3F, 1, rx);
    chk(rx[7:0], 8'h00);
    conv(24'hA5C3E1, 4'h5);
    chk(rdy_n, 1'b0);
    rd(adcr_pkg::ADDR_DATA, 3, rx);
    chk(rx[23:0], 24'hA5C3E1);
    chk(rdy_n, 1'b1);
    rd(adcr_pkg::ADDR_DATA, 3, rx);
    chk(rx[23:0], 24'hA5C3E1);
    conv(24'h3C5A69, 4'h2);
    fork
      rd(adcr_pkg::ADDR_DATA, 3, rx);
      begin
        step(250);
        conv(24'h0F0F0F, 4'h7);
      end
    join
    chk(rx[23:0], 24'h3C5A69);
    adcr_host_model_inst.xfer(16, {50'h0, adcr_pkg::ADDR_DATA, 8'hFF}, rx);
    rd(adcr_pkg::ADDR_DATA, 3, rx);
    chk(rx[23:0], 24'h3C5A69);
    wr(adcr_pkg::ADDR_USER_BASE, 16'h1000, 0);
    chk(polarity_select, 1'b1);
    wr(adcr_pkg::ADDR_MODE, 16'h0041, 0);
    conv(24'h123456, 4'h3);
    rd(adcr_pkg::ADDR_DATA, 3, rx);
    chk(rx[23:8], 16'h1234);
    chk(rx[3:0], 4'h3);
    wr(adcr_pkg::ADDR_MODE, 16'h0000, 0);
    wr(adcr_pkg::ADDR_USER_BASE + 6'h01, 16'h00F0, 0);
    rd(adcr_pkg::ADDR_CHECKSUM, 3, rx);
    chk(rx[23:0], 24'h000000);
    wr(adcr_pkg::ADDR_MODE, 16'h0020, 0);
    rd(adcr_pkg::ADDR_CHECKSUM, 3, rx);
    chk(rx[23:0], 24'h0010F0);
    wr(adcr_pkg::ADDR_USER_BASE + 6'h01, 16'h0F00, 0);
    rd(adcr_pkg::ADDR_CHECKSUM, 3, rx);
    chk(rx[23:0], 24'h001F00);
    rd(adcr_pkg::ADDR_STATUS, 1, rx);
    chk(rx[6], 1'b1);
    wr(adcr_pkg::ADDR_MODE, 16'h0004, 0);
    rd(adcr_pkg::ADDR_STATUS, 1, rx);
    chk(rx[14], 1'b0);
    rd(adcr_pkg::ADDR_MODE, 3, rx);
    chk(rx[23:0], 24'h000446);
    wr(adcr_pkg::ADDR_USER_BASE + 6'h02, 16'h0ABC, 1);
    rd(adcr_pkg::ADDR_USER_BASE + 6'h02, 3, rx);
    chk(rx[23:8], 16'h0ABC);
    chk(rx[7:0], 8'hD4);
    resetn = 1'b0;
    step(3);
    resetn = 1'b1;
    step(4);
    rd(adcr_pkg::ADDR_MODE, 2, rx);
    chk(rx[15:0], 16'h0000);
    wr(adcr_pkg::ADDR_MODE, 16'h0008, 0);
    wr(adcr_pkg::ADDR_USER_BASE, 16'h1000, 2);
    chk(polarity_select, 1'b0);
    wr(adcr_pkg::ADDR_USER_BASE, 16'h1000, 1);
    chk(polarity_select, 1'b1);
    end_of_test;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    end_of_test;
  end
endmodule
